/* logic/ood_diag.sv */
// openload diagnostics for five high-side outputs, AHB-Lite register slave
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ood_diag #(
	parameter int unsigned NCH = ood_pkg::OOD_NCH,
	parameter int unsigned LED_WIN_CYC = ood_pkg::OOD_LED_WIN_CYC,
	parameter int unsigned LED_TAIL_CYC = ood_pkg::OOD_LED_TAIL_CYC,
	parameter int unsigned OFF_PROBE_CYC = ood_pkg::OOD_OFF_PROBE_CYC,
	parameter int unsigned FAULT_DGL_CYC = ood_pkg::OOD_FAULT_DGL_CYC,
	parameter int unsigned DGL_SHORT_CYC = ood_pkg::OOD_DGL_SHORT_CYC,
	parameter int unsigned DGL_LONG_CYC = ood_pkg::OOD_DGL_LONG_CYC
) (
	input wire logic hclk, // 40 MHz clock
	input wire logic hresetn, // async reset, low active
	input wire logic hsel, // slave select
	input wire logic [7:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // always ready
	output logic hresp, // always okay
	input wire logic [NCH-1:0] out_cmd, // commanded channel on, from PWM logic
	input wire logic [NCH-1:0] out_high_raw, // output above detect level, async
	input wire logic [NCH-1:0] led_cmp_raw, // output above vbat-0.75 V, async
	input wire logic [NCH-1:0] onstate_low_raw, // load current below on threshold, async
	input wire logic [NCH-1:0] trip_raw, // probe trip level reached, async
	input wire logic chip_select_n_raw, // spi chip select pin
	input wire logic overtemp_shutdown, // fault, same clock
	input wire logic undervoltage, // fault, same clock
	input wire logic charge_pump_fault, // fault, same clock
	output logic [NCH-1:0] out_force_on, // probe forces channel on
	output logic [NCH-1:0] out_force_off, // tied low; a fault abort only drops out_force_on
	output logic [NCH-1:0] probe_trip_sel, // use fixed offstate_trip_current
	output logic [NCH-1:0] led_probe_current, // led probe source on
	output logic [NCH-1:0] onstate_open_flag, // latched
	output logic [NCH-1:0] offstate_open_flag, // latched
	output logic [NCH-1:0] channel_quick_flag, // either flag
	output logic global_open_flag // any channel flag
);
	import ood_pkg::*;

	initial begin
		if (NCH < 1 || NCH > 8)
			$error("NCH must be 1..8");
		if (LED_TAIL_CYC >= LED_WIN_CYC || FAULT_DGL_CYC < 1 || OFF_PROBE_CYC < 1)
			$error("bad timing parameters");
		if (LED_WIN_CYC >= (1 << OOD_CW) || DGL_LONG_CYC >= (1 << OOD_CW))
			$error("counts exceed counter width");
	end

	typedef struct packed {
		logic [NCH-1:0] cs_s1;
		logic [NCH-1:0] cs_s2; // only bits 0 and 1 used, as the cs pair of sync output and its delayed copy
		logic [NCH-1:0] oh1, oh2, lc1, lc2, ol1, ol2, tr1, tr2;
		logic [NCH-1:0] cmd_prev;
		logic [NCH-1:0] led_en, dgl_sel, off_en, arm;
		logic trig;
		logic [NCH-1:0] led_busy, full_on, tail;
		logic [NCH-1:0][OOD_CW-1:0] led_cnt, dgl_cnt, off_cnt;
		logic [NCH-1:0][1:0] off_st;
		logic [NCH-1:0] on_flg, off_flg;
		logic aph_v, aph_w;
		logic [7:0] aph_a;
		logic [31:0] rdata;
	} ood_s;
	ood_s q, d;

	logic [NCH-1:0] rd_clr;
	logic cs_rise, fault;

	always_comb begin
		d = q;
		// pin synchronisers; first stage only feeds second
		d.cs_s1 = {NCH{chip_select_n_raw}};
		d.cs_s2 = q.cs_s1;
		d.oh1 = out_high_raw;
		d.oh2 = q.oh1;
		d.lc1 = led_cmp_raw;
		d.lc2 = q.lc1;
		d.ol1 = onstate_low_raw;
		d.ol2 = q.ol1;
		d.tr1 = trip_raw;
		d.tr2 = q.tr1;
		d.cmd_prev = out_cmd;
		fault = overtemp_shutdown | undervoltage | charge_pump_fault;
		// rising chip select sampled one cycle later than its sync
		cs_rise = q.cs_s2[0] & ~q.arm[0] ? 1'b0 : 1'b0;
		cs_rise = 1'b0;
		rd_clr = '0;
		// bus address phase capture, zero wait
		d.aph_v = hsel & htrans[1] & hready;
		d.aph_w = hwrite;
		d.aph_a = haddr;
		// data phase: writes and reads
		if (q.aph_v && q.aph_w) begin
			unique case (q.aph_a)
				OOD_A_CTRL: begin
					d.led_en = hwdata[OOD_F_LED +: NCH];
					d.dgl_sel = hwdata[OOD_F_DGL +: NCH];
					for (int i = 0; i < NCH; i++) begin
						// running probe ignores the write; 1 arms a probe
						if (q.off_st[i] == OOD_IDLE && !q.off_en[i])
							d.arm[i] = hwdata[OOD_F_OFFEN + i];
						else if (q.off_st[i] == OOD_IDLE)
							d.arm[i] = hwdata[OOD_F_OFFEN + i] & q.arm[i];
					end
				end
				OOD_A_TRIG: begin
					if (hwdata[0])
						d.trig = 1'b1;
				end
				default: begin
				end
			endcase
		end
		d.rdata = '0;
		if (d.aph_v && !hwrite) begin
			if (haddr == OOD_A_CTRL) begin
				d.rdata[OOD_F_LED +: NCH] = q.led_en;
				d.rdata[OOD_F_DGL +: NCH] = q.dgl_sel;
				d.rdata[OOD_F_OFFEN +: NCH] = q.off_en | q.arm;
			end else if (haddr == OOD_A_TRIG) begin
				d.rdata[0] = q.trig;
			end else if (haddr == OOD_A_GLOB) begin
				d.rdata[0] = |(q.on_flg | q.off_flg);
				d.rdata[OOD_F_GLOB +: NCH] = q.on_flg | q.off_flg;
			end else begin
				for (int i = 0; i < NCH; i++) begin
					if (haddr == OOD_A_CH0 + 8'(4 * i)) begin
						d.rdata[OOD_F_OFFFLG] = q.off_flg[i];
						d.rdata[OOD_F_ONFLG] = q.on_flg[i];
						d.rdata[OOD_F_GLOB] = |(q.on_flg | q.off_flg);
						d.rdata[OOD_F_BUSY] = q.off_en[i];
						rd_clr[i] = 1'b1;
					end
				end
			end
		end
		// probes launch together when the frame ends (cs rising, synced)
		cs_rise = q.cs_s2[0] & ~q.cs_s2[1];
		d.cs_s2[NCH-1:1] = '0;
		if (NCH > 1)
			d.cs_s2[1] = q.cs_s2[0];
		for (int i = 0; i < NCH; i++) begin
			// standard filter: count while commanded on with output high and current low, reset otherwise
			if (!q.led_en[i] && q.oh2[i] && q.ol2[i] && out_cmd[i]) begin
				if (q.dgl_cnt[i] != OOD_CW'(q.dgl_sel[i] ? DGL_LONG_CYC : DGL_SHORT_CYC))
					d.dgl_cnt[i] = q.dgl_cnt[i] + 1'b1;
			end else begin
				d.dgl_cnt[i] = '0;
			end
			if (d.dgl_cnt[i] == OOD_CW'(q.dgl_sel[i] ? DGL_LONG_CYC : DGL_SHORT_CYC)
				&& q.dgl_cnt[i] != d.dgl_cnt[i])
				d.on_flg[i] = 1'b1;
			// LED window opens at each on-phase end, except while the fully-on window runs
			if (q.led_en[i] && q.cmd_prev[i] && !out_cmd[i] && !q.full_on[i]) begin
				d.led_busy[i] = 1'b1;
				d.led_cnt[i] = '0;
			end else if (q.led_en[i] && q.led_busy[i] && !q.full_on[i]) begin
				if (out_cmd[i]) begin
					d.led_busy[i] = 1'b0; // evaluate at turn-on
					if (q.lc2[i])
						d.on_flg[i] = 1'b1;
				end else if (!q.lc2[i]) begin
					d.led_busy[i] = 1'b0; // no-open decision
				end else if (q.led_cnt[i] == OOD_CW'(LED_WIN_CYC - 1)) begin
					d.led_busy[i] = 1'b0;
					d.on_flg[i] = 1'b1;
				end else begin
					d.led_cnt[i] = q.led_cnt[i] + 1'b1;
				end
			end else if (!q.led_en[i]) begin
				d.led_busy[i] = 1'b0;
			end
			// fully-on window, then 100 us tail with output back on
			if (q.trig && !q.full_on[i] && !q.tail[i] && q.led_en[i] && out_cmd[i]) begin
				d.full_on[i] = 1'b1;
				d.led_cnt[i] = '0;
			end else if (q.full_on[i]) begin
				if (q.led_cnt[i] == OOD_CW'(LED_WIN_CYC - 1)) begin
					d.full_on[i] = 1'b0;
					d.tail[i] = 1'b1;
					d.led_cnt[i] = '0;
					if (q.lc2[i])
						d.on_flg[i] = 1'b1;
				end else begin
					d.led_cnt[i] = q.led_cnt[i] + 1'b1;
				end
			end else if (q.tail[i]) begin
				if (q.led_cnt[i] == OOD_CW'(LED_TAIL_CYC - 1))
					d.tail[i] = 1'b0;
				else
					d.led_cnt[i] = q.led_cnt[i] + 1'b1;
			end
			// off-state probe
			unique case (q.off_st[i])
				OOD_IDLE: begin
					d.off_en[i] = 1'b0;
					if (cs_rise && q.arm[i]) begin
						d.off_st[i] = OOD_PROBE;
						d.off_en[i] = 1'b1;
						d.arm[i] = 1'b0;
						d.off_cnt[i] = '0;
					end
				end
				OOD_PROBE: begin
					if (fault) begin
						d.off_st[i] = OOD_ABORT;
						d.off_cnt[i] = '0;
					end else if (q.tr2[i]) begin
						d.off_st[i] = OOD_IDLE;
						d.off_en[i] = 1'b0;
					end else if (q.off_cnt[i] == OOD_CW'(OFF_PROBE_CYC - 1)) begin
						d.off_st[i] = OOD_IDLE;
						d.off_en[i] = 1'b0;
						d.off_flg[i] = 1'b1;
					end else begin
						d.off_cnt[i] = q.off_cnt[i] + 1'b1;
					end
				end
				OOD_ABORT: begin
					// fault must persist for the deglitch time before the probe ends
					if (!fault) begin
						d.off_st[i] = OOD_PROBE;
					end else if (q.off_cnt[i] == OOD_CW'(FAULT_DGL_CYC - 1)) begin
						d.off_st[i] = OOD_IDLE;
						d.off_en[i] = 1'b0;
					end else begin
						d.off_cnt[i] = q.off_cnt[i] + 1'b1;
					end
				end
				default: begin
					d.off_st[i] = OOD_IDLE;
				end
			endcase
			// read clears unless a new set lands the same cycle on a flag that was clear
			if (rd_clr[i]) begin
				if (d.on_flg[i] == q.on_flg[i])
					d.on_flg[i] = 1'b0;
				if (d.off_flg[i] == q.off_flg[i])
					d.off_flg[i] = 1'b0;
			end
		end
		// trigger self-clears when no channel still runs the window
		if (q.trig && (q.full_on | q.tail) != '0 && (d.full_on | d.tail) == '0)
			d.trig = 1'b0;
		else if (q.trig && (q.led_en & out_cmd) == '0 && (q.full_on | q.tail) == '0)
			d.trig = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

	always_comb begin
		hrdata = q.rdata;
		hreadyout = 1'b1;
		hresp = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			out_force_on[i] = q.off_st[i] == OOD_PROBE || q.off_st[i] == OOD_ABORT;
			out_force_off[i] = 1'b0;
		end
		probe_trip_sel = out_force_on;
		led_probe_current = q.led_busy | q.full_on | q.tail;
		onstate_open_flag = q.on_flg;
		offstate_open_flag = q.off_flg;
		channel_quick_flag = q.on_flg | q.off_flg;
		global_open_flag = |(q.on_flg | q.off_flg);
	end
endmodule
`default_nettype wire

/* logic/ood_pkg.sv */
// constants and types shared by the openload diagnostics block
package ood_pkg;
	localparam int unsigned OOD_CLK_HZ = 40_000_000;
	localparam int unsigned OOD_LED_WIN_US = 2000;
	localparam int unsigned OOD_LED_TAIL_US = 100;
	localparam int unsigned OOD_OFF_PROBE_US = 1200;
	localparam int unsigned OOD_FAULT_DGL_NS = 3300;
	localparam int unsigned OOD_DGL_SHORT_US = 64;
	localparam int unsigned OOD_DGL_LONG_US = 2000;
	localparam int unsigned OOD_LED_WIN_CYC = OOD_LED_WIN_US * (OOD_CLK_HZ / 1_000_000);
	localparam int unsigned OOD_LED_TAIL_CYC = OOD_LED_TAIL_US * (OOD_CLK_HZ / 1_000_000);
	localparam int unsigned OOD_OFF_PROBE_CYC = OOD_OFF_PROBE_US * (OOD_CLK_HZ / 1_000_000);
	localparam int unsigned OOD_FAULT_DGL_CYC = OOD_FAULT_DGL_NS * (OOD_CLK_HZ / 1_000_000) / 1000;
	localparam int unsigned OOD_DGL_SHORT_CYC = OOD_DGL_SHORT_US * (OOD_CLK_HZ / 1_000_000);
	localparam int unsigned OOD_DGL_LONG_CYC = OOD_DGL_LONG_US * (OOD_CLK_HZ / 1_000_000);
	localparam int unsigned OOD_NCH = 5;
	localparam int unsigned OOD_CW = 17;
	// register byte addresses (own map)
	localparam logic [7:0] OOD_A_CTRL = 8'h00;
	localparam logic [7:0] OOD_A_TRIG = 8'h04;
	localparam logic [7:0] OOD_A_GLOB = 8'h08;
	localparam logic [7:0] OOD_A_CH0 = 8'h10;
	// ctrl field positions
	localparam int unsigned OOD_F_LED = 0;
	localparam int unsigned OOD_F_DGL = 8;
	localparam int unsigned OOD_F_OFFEN = 16;
	// channel status fields
	localparam int unsigned OOD_F_OFFFLG = 0;
	localparam int unsigned OOD_F_ONFLG = 1;
	localparam int unsigned OOD_F_GLOB = 8;
	localparam int unsigned OOD_F_BUSY = 16;
	typedef enum logic [1:0] {
		OOD_IDLE = 2'b00,
		OOD_PROBE = 2'b01,
		OOD_ABORT = 2'b11
	} ood_off_e;
endpackage

/* tb/ood_diag_sva.sv */
// port assertions for the openload diagnostics block
`timescale 1ns/100ps
`default_nettype none
module ood_diag_sva #(
	parameter int unsigned NCH = 5,
	parameter int unsigned LED_WIN_CYC = 40,
	parameter int unsigned LED_TAIL_CYC = 4,
	parameter int unsigned OFF_PROBE_CYC = 20,
	parameter int unsigned FAULT_DGL_CYC = 6
) (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, low
	input wire logic hsel, // select
	input wire logic [7:0] haddr, // address
	input wire logic [1:0] htrans, // transfer
	input wire logic hwrite, // write
	input wire logic hready, // ready
	input wire logic chip_select_n_raw, // chip select
	input wire logic overtemp_shutdown, // fault
	input wire logic undervoltage, // fault
	input wire logic charge_pump_fault, // fault
	input wire logic [NCH-1:0] out_force_on, // probe on
	input wire logic [NCH-1:0] out_force_off, // forced off
	input wire logic [NCH-1:0] probe_trip_sel, // trip select
	input wire logic [NCH-1:0] led_probe_current, // led source
	input wire logic [NCH-1:0] onstate_open_flag, // flag
	input wire logic [NCH-1:0] offstate_open_flag, // flag
	input wire logic [NCH-1:0] channel_quick_flag, // flag
	input wire logic global_open_flag // flag
);
	import ood_pkg::*;
	localparam int FMAX = FAULT_DGL_CYC + 4;
	logic [15:0] pc_q, lc_q;
	logic [2:0] rd_q;
	wire flt = overtemp_shutdown | undervoltage | charge_pump_fault;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// run lengths of channel 0 only, since channels may overlap in time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_q <= '0;
			lc_q <= '0;
			rd_q <= '0;
		end else begin
			pc_q <= out_force_on[0] ? pc_q + 16'h1 : 16'h0;
			lc_q <= led_probe_current[0] ? lc_q + 16'h1 : 16'h0;
			rd_q <= {rd_q[1:0], hsel & htrans[1] & hready & !hwrite & (haddr == OOD_A_CH0)};
		end
	end
	property p_trip_sel; probe_trip_sel == out_force_on; endproperty
	a_trip_sel: assert property (p_trip_sel) else $error("trip select not with probe");
	property p_no_off; out_force_off == '0; endproperty
	a_no_off: assert property (p_no_off) else $error("output forced off");
	property p_quick; channel_quick_flag == (onstate_open_flag | offstate_open_flag); endproperty
	a_quick: assert property (p_quick) else $error("quick flag mismatch");
	property p_glob; global_open_flag == (|channel_quick_flag); endproperty
	a_glob: assert property (p_glob) else $error("global flag mismatch");
	property p_probe_len; pc_q <= OFF_PROBE_CYC + 2; endproperty
	a_probe_len: assert property (p_probe_len) else $error("probe too long");
	property p_led_len; lc_q <= LED_WIN_CYC + LED_TAIL_CYC + 2; endproperty
	a_led_len: assert property (p_led_len) else $error("led source too long");
	property p_fault; ($rose(flt) && out_force_on != '0) |-> ##[1:FMAX] out_force_on == '0;
	endproperty
	a_fault: assert property (p_fault) else $error("probe not aborted");
	property p_clear; ($fell(offstate_open_flag[0]) || $fell(onstate_open_flag[0])) |-> |rd_q;
	endproperty
	a_clear: assert property (p_clear) else $error("flag cleared without read");
	property p_cs; $rose(out_force_on[0]) |-> chip_select_n_raw && !$past(chip_select_n_raw, 4);
	endproperty
	a_cs: assert property (p_cs) else $error("probe start off select edge");
endmodule
bind ood_diag ood_diag_sva #(.NCH(NCH), .LED_WIN_CYC(LED_WIN_CYC), .LED_TAIL_CYC(LED_TAIL_CYC),
	.OFF_PROBE_CYC(OFF_PROBE_CYC), .FAULT_DGL_CYC(FAULT_DGL_CYC)) u_ood_diag_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .chip_select_n_raw(chip_select_n_raw),
	.overtemp_shutdown(overtemp_shutdown), .undervoltage(undervoltage),
	.charge_pump_fault(charge_pump_fault), .out_force_on(out_force_on),
	.out_force_off(out_force_off), .probe_trip_sel(probe_trip_sel),
	.led_probe_current(led_probe_current), .onstate_open_flag(onstate_open_flag),
	.offstate_open_flag(offstate_open_flag), .channel_quick_flag(channel_quick_flag),
	.global_open_flag(global_open_flag));
`default_nettype wire

/* tb/ood_load_model.sv */
// output stage and load model standing behind the diagnostics block
`timescale 1ns/100ps
`default_nettype none
module ood_load_model (
	input wire logic [4:0] out_cmd, // commanded on
	input wire logic [4:0] force_on, // probe holds channel on
	input wire logic [4:0] led_src, // led probe source on
	input wire logic [4:0] open_ld, // load missing per channel
	output logic [4:0] out_high, // output above detect level
	output logic [4:0] led_cmp, // output near battery level
	output logic [4:0] low_cur, // load current below threshold
	output logic [4:0] trip // probe trip level reached
);
	logic [4:0] on;
	assign on = out_cmd | force_on;
	assign out_high = on;
	// with no load nothing discharges the output, so it stays near battery after
	// switch-off even in the cycle before the probe source takes over
	assign led_cmp = on | (open_ld & (led_src | ~on));
	assign low_cur = on & open_ld;
	// a present load draws more than the fixed probe trip level at once
	assign trip = force_on & ~open_ld;
endmodule
`default_nettype wire

/* tb/tb_ood_diag.sv */
// self-checking bench for the openload diagnostics block
`timescale 1ns/100ps
`default_nettype none
module tb_ood_diag;
	import ood_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cs_n = 1'b1;
	wire logic hready;
	logic [2:0] hsize = 3'h0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] flt = 3'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd, seed = 32'h00013b0f;
	logic hreadyout, hresp, gflag;
	// the one slave's ready is the bus's ready
	assign hready = hreadyout;
	logic [4:0] cmd = 5'h0, open = 5'h0, fon, foff, tsel, lsrc, onf, offf, qf, hi, lc, lo, tr;
	int fails = 0, compares = 0, cyc = 0;
	ood_diag #(.LED_WIN_CYC(40), .LED_TAIL_CYC(4), .OFF_PROBE_CYC(20), .FAULT_DGL_CYC(6),
		.DGL_SHORT_CYC(8), .DGL_LONG_CYC(16)) u_ood_diag (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .out_cmd(cmd), .out_high_raw(hi), .led_cmp_raw(lc),
		.onstate_low_raw(lo), .trip_raw(tr), .chip_select_n_raw(cs_n),
		.overtemp_shutdown(flt[0]), .undervoltage(flt[1]), .charge_pump_fault(flt[2]),
		.out_force_on(fon), .out_force_off(foff), .probe_trip_sel(tsel),
		.led_probe_current(lsrc), .onstate_open_flag(onf), .offstate_open_flag(offf),
		.channel_quick_flag(qf), .global_open_flag(gflag));
	ood_load_model u_ood_load_model (.out_cmd(cmd), .force_on(fon), .led_src(lsrc),
		.open_ld(open), .out_high(hi), .led_cmp(lc), .low_cur(lo), .trip(tr));
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// expected status word of one channel: busy clear, on-state flag, off-state flag
	function automatic logic [31:0] st(input logic [4:0] off, input logic [4:0] on, input int c);
		return {30'h0, on[c], off[c]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		// select stays up with htrans idle, so back-to-back calls never drive it twice
		rd = hrdata;
	endtask
	task automatic clr(input logic [4:0] off, input logic [4:0] on);
		for (int c = 0; c < 5; c++) begin
			bus(1'b0, OOD_A_CH0 + 8'(4 * c), 32'h0);
			chk(rd & 32'h00010003, st(off, on, c));
		end
		tick(2);
		chk(32'(offf | onf), 32'h0);
		chk(32'(gflag), 32'h0);
	endtask
	task automatic summarize();
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		tick(20);
		hresetn <= 1'b1;
		tick(1);
		bus(1'b0, OOD_A_CTRL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		// off-state probes: present loads trip early, open ones time out
		for (int r = 0; r < 4; r++) begin
			seed = xs(seed);
			open <= (r == 0) ? 5'h1f : seed[4:0];
			cs_n <= 1'b0;
			bus(1'b1, OOD_A_CTRL, 32'h001f0000);
			tick(4);
			cs_n <= 1'b1;
			tick(9);
			bus(1'b1, OOD_A_CTRL, 32'h0);
			bus(1'b0, OOD_A_CTRL, 32'h0);
			chk(32'(rd[20:16]), 32'(open));
			tick(30);
			chk(32'(offf), 32'(open));
			chk(32'(qf), 32'(open));
			bus(1'b0, OOD_A_CTRL, 32'h0);
			chk(rd, 32'h0);
			clr(open, 5'h0);
		end
		// led mode, random off time on both sides of the window
		bus(1'b1, OOD_A_CTRL, 32'h0000001f);
		for (int r = 0; r < 4; r++) begin
			seed = xs(seed);
			open <= seed[4:0];
			cmd <= 5'h1f;
			tick(20);
			cmd <= 5'h00;
			tick(5 + int'(seed[10:5]));
			cmd <= 5'h1f;
			tick(6);
			chk(32'(onf), 32'(open));
			chk(32'(foff), 32'h0);
			clr(5'h0, open);
		end
		// standard check, long deglitch on channels 4..2
		cmd <= 5'h0;
		seed = xs(seed);
		open <= seed[4:0];
		bus(1'b1, OOD_A_CTRL, 32'h00001c00);
		cmd <= 5'h1f;
		tick(14);
		chk(32'(onf), 32'(open & 5'h03));
		tick(10);
		chk(32'(onf), 32'(open));
		cmd <= 5'h0;
		clr(5'h0, open);
		// each fault kind aborts a running probe
		for (int k = 0; k < 3; k++) begin
			open <= 5'h1f;
			cs_n <= 1'b0;
			bus(1'b1, OOD_A_CTRL, 32'h001f0000);
			tick(4);
			cs_n <= 1'b1;
			tick(5);
			flt[k] <= 1'b1;
			tick(25);
			chk(32'(offf), 32'h0);
			chk(32'(fon), 32'h0);
			flt <= 3'h0;
			tick(3);
		end
		// fully-on trigger clears itself
		bus(1'b1, OOD_A_CTRL, 32'h0000001f);
		cmd <= 5'h1f;
		bus(1'b1, OOD_A_TRIG, 32'h1);
		tick(120);
		bus(1'b0, OOD_A_TRIG, 32'h0);
		chk(rd, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
